// *** verilog/wdt_unit.sv ***
`timescale 1ns/100ps
// Contract
// [RQ1] counter divides the system clock; selected divider output sets the time-out
// [RQ2] select codes 00..11 give 2^17, 2^20, 2^23, 2^26 clocks
// [RQ3] interval select resets to the shortest time-out, 2^17 clocks
// [RQ4] reaching the selected time-out sets the time-out flag, control bit 3
// [RQ5] time-out flag requests interrupt only with watchdog and global enables set
// [RQ6] interrupt path and reset path are controlled independently
// [RQ7] 512 clocks after time-out, without restart and with enable, reset fires
// [RQ8] watchdog reset lasts two machine cycles and sets the reset-cause flag
// [RQ9] writing 1 to restart bit clears the counter; the bit self-clears
// [RQ10] reset-enable bit gates only the reset; the counter keeps running
// [RQ11] with both paths off the flag sets every interval for polling
// [RQ12] power-on reset disables the watchdog; its own reset only restarts it
// [RQ13] time-out flag cleared by software write or any reset
// [RQ14] reset-cause flag cleared only by software or power reset
// [RQ15] reset-enable, time-out flag and restart writes need timed access
// [RQ16] software should restart the watchdog before relying on it
// [RQ17] protected writes without a valid unlock leave the bits unchanged
// [RQ18] 26-bit interval counter plus separate 9-bit reset delay count
module wdt_unit #(
   parameter int unsigned TIMEOUT_CLKS_0 = 131072,
   parameter int unsigned TIMEOUT_CLKS_1 = 1048576,
   parameter int unsigned TIMEOUT_CLKS_2 = 8388608,
   parameter int unsigned TIMEOUT_CLKS_3 = 67108864
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [wdt_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [wdt_pkg::STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [wdt_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq,
   output logic wdtIrqReq,
   output logic wdtSysRst
);
   import wdt_pkg::*;

   // bus side
   logic wrEn;
   logic [ADDR_W-1:0] wrAddr;
   logic [DATA_W-1:0] wrData;
   logic [STRB_W-1:0] wrStrb;
   logic wrErr;
   logic rdEn;
   logic [DATA_W-1:0] rdData;
   logic rdErr;

   // register state
   logic timeoutFlagQ;
   logic rstCauseQ;
   logic rstEnQ;
   logic restartQ;
   logic [REG_W-1:0] clkCtrlQ;
   logic [REG_W-1:0] extIeQ;
   logic glbIeQ;
   logic [IRQ_W-1:0] irqStatQ;
   logic [IRQ_W-1:0] irqMaskQ;

   // counting state
   logic [CNT_W-1:0] cntQ;
   logic [CNT_W-1:0] selMask;
   logic tick;
   logic dlyActQ;
   logic [DLY_W-1:0] dlyCntQ;
   logic fire;
   logic [PULSE_W-1:0] pulseCntQ;
   logic sysRstQ;

   // write decode
   logic byteWr;
   logic wdCtrlWr;
   logic clkCtrlWr;
   logic taKeyWr;
   logic extIeWr;
   logic glbIeWr;
   logic statWr;
   logic maskWr;
   logic taOpen;
   logic protWr;
   logic [REG_W-1:0] wrByte;
   logic [IRQ_W-1:0] irqEvents;

   function automatic logic [ADDR_W-1:0] wordOf(input logic [ADDR_W-1:0] addr);
      wordOf = {addr[ADDR_W-1:2], 2'b00};
   endfunction

   function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
      case (wordOf(addr))
         OFF_WD_CTRL,
         OFF_CLK_CTRL,
         OFF_TA_KEY,
         OFF_EXT_IE,
         OFF_GLB_IE,
         OFF_IRQ_STAT,
         OFF_IRQ_MASK,
         OFF_COUNT: isMapped = 1'b1;
         default: isMapped = 1'b0;
      endcase
   endfunction

   wdt_axil_slave u_slave (
      .clock(clock),
      .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wrEn(wrEn),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .wrStrb(wrStrb),
      .wrErr(wrErr),
      .rdEn(rdEn),
      .rdData(rdData),
      .rdErr(rdErr)
   );

   // all writable registers are one byte wide, so only lane 0 carries a write
   assign wrByte = wrData[REG_W-1:0];
   assign byteWr = wrEn && wrStrb[0];
   assign wrErr = !isMapped(wrAddr);
   assign rdErr = !isMapped(s_axi_araddr);
   assign wdCtrlWr = byteWr && wordOf(wrAddr) == OFF_WD_CTRL;
   assign clkCtrlWr = byteWr && wordOf(wrAddr) == OFF_CLK_CTRL;
   assign taKeyWr = byteWr && wordOf(wrAddr) == OFF_TA_KEY;
   assign extIeWr = byteWr && wordOf(wrAddr) == OFF_EXT_IE;
   assign glbIeWr = byteWr && wordOf(wrAddr) == OFF_GLB_IE;
   assign statWr = byteWr && wordOf(wrAddr) == OFF_IRQ_STAT;
   assign maskWr = byteWr && wordOf(wrAddr) == OFF_IRQ_MASK;

   wdt_timed_access u_ta (
      .clock(clock),
      .rst_n(rst_n),
      .keyWr(taKeyWr),
      .keyData(wrByte),
      .unlocked(taOpen)
   );

   // errant code cannot touch the guarded bits without the key sequence
   assign protWr = wdCtrlWr && taOpen; // [RQ15] [RQ17]

   always_comb begin
      case (clkCtrlQ[BIT_SEL_HI:BIT_SEL_LO])
         2'h0: selMask = CNT_W'(TIMEOUT_CLKS_0 - 1); // [RQ2]
         2'h1: selMask = CNT_W'(TIMEOUT_CLKS_1 - 1); // [RQ2]
         2'h2: selMask = CNT_W'(TIMEOUT_CLKS_2 - 1); // [RQ2]
         2'h3: selMask = CNT_W'(TIMEOUT_CLKS_3 - 1); // [RQ2]
         default: selMask = CNT_W'(TIMEOUT_CLKS_0 - 1);
      endcase
   end

   // time-out when the selected low bits of the divider chain are all ones
   assign tick = (cntQ & selMask) == selMask; // [RQ1]

   // free-running divider; restart and the watchdog's own reset bring it to zero
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cntQ <= '0;
      end else if (restartQ || sysRstQ) begin
         cntQ <= '0; // [RQ9] [RQ12]
      end else begin
         cntQ <= cntQ + 1'b1; // [RQ1] [RQ10] [RQ11] [RQ18]
      end
   end

   // restart bit is high for one cycle after a guarded write of 1
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         restartQ <= 1'b0;
      end else begin
         restartQ <= protWr && wrByte[BIT_RESTART]; // [RQ9] [RQ15]
      end
   end

   // reset delay starts on each time-out that finds no delay running, regardless of the enable,
   // the enable is looked at only on the last clock
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dlyActQ <= 1'b0;
         dlyCntQ <= '0;
      end else if (restartQ || sysRstQ) begin
         dlyActQ <= 1'b0;
         dlyCntQ <= '0;
      end else if (!dlyActQ) begin
         if (tick) begin
            dlyActQ <= 1'b1; // [RQ7]
            dlyCntQ <= '0;
         end
      end else if (dlyCntQ == DLY_LAST) begin
         dlyActQ <= 1'b0;
      end else begin
         dlyCntQ <= dlyCntQ + 1'b1; // [RQ7] [RQ18]
      end
   end

   // a restart written in the clock before the last delay clock still wins over the reset
   assign fire = dlyActQ && dlyCntQ == DLY_LAST && rstEnQ && !restartQ && !sysRstQ; // [RQ7] [RQ10]

   // watchdog reset pulse, two machine cycles long
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pulseCntQ <= '0;
         sysRstQ <= 1'b0;
      end else if (fire) begin
         pulseCntQ <= RST_PULSE_CLKS - 1'b1; // [RQ8]
         sysRstQ <= 1'b1;
      end else if (pulseCntQ != '0) begin
         pulseCntQ <= pulseCntQ - 1'b1;
      end else begin
         sysRstQ <= 1'b0;
      end
   end

   assign wdtSysRst = sysRstQ;

   // time-out flag: hardware set beats a clearing write in the same cycle;
   // cleared at the end of the reset pulse's first clock and held clear for the rest of it, even if a tick meets the fire edge
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         timeoutFlagQ <= 1'b0; // [RQ13]
      end else if (sysRstQ) begin
         timeoutFlagQ <= 1'b0; // [RQ13]
      end else if (tick) begin
         timeoutFlagQ <= 1'b1; // [RQ4] [RQ11]
      end else if (protWr) begin
         timeoutFlagQ <= wrByte[BIT_TIMEOUT]; // [RQ13] [RQ15]
      end
   end

   // reset-cause flag survives the watchdog's own reset; only power reset or software clears
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rstCauseQ <= 1'b0; // [RQ14]
      end else if (fire) begin
         rstCauseQ <= 1'b1; // [RQ8] [RQ14]
      end else if (wdCtrlWr && !wrByte[BIT_RST_CAUSE]) begin
         rstCauseQ <= 1'b0; // [RQ14]
      end
   end

   // power reset leaves the reset function off; the watchdog reset does not touch it
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rstEnQ <= 1'b0; // [RQ12]
      end else if (protWr) begin
         rstEnQ <= wrByte[BIT_RST_EN]; // [RQ10] [RQ15]
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         clkCtrlQ <= CLK_CTRL_RST; // [RQ3]
      end else if (clkCtrlWr) begin
         clkCtrlQ <= wrByte;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         extIeQ <= EXT_IE_RST;
         glbIeQ <= 1'b0;
      end else begin
         if (extIeWr) begin
            extIeQ <= wrByte;
         end
         if (glbIeWr) begin
            glbIeQ <= wrByte[BIT_GLB_IE];
         end
      end
   end

   // the interrupt request depends only on the flag and its enables, never on reset enable
   assign wdtIrqReq = timeoutFlagQ && extIeQ[BIT_WD_IE] && glbIeQ; // [RQ5] [RQ6]

   assign irqEvents[IRQ_TIMEOUT] = tick && !sysRstQ;
   assign irqEvents[IRQ_WD_RST] = fire;

   // sticky event bits, write one to clear, a new event wins over the clear
   genvar gi;
   generate
      for (gi = 0; gi < IRQ_W; gi++) begin : g_stat
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               irqStatQ[gi] <= 1'b0;
            end else if (irqEvents[gi]) begin
               irqStatQ[gi] <= 1'b1;
            end else if (statWr && wrByte[gi]) begin
               irqStatQ[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irqMaskQ <= '0;
      end else if (maskWr) begin
         irqMaskQ <= wrByte[IRQ_W-1:0];
      end
   end

   assign irq = |(irqStatQ & irqMaskQ);

   // read mux; the restart bit reads back its self-clearing state
   always_comb begin
      rdData = '0;
      case (wordOf(s_axi_araddr))
         OFF_WD_CTRL: begin
            rdData[BIT_TIMEOUT] = timeoutFlagQ;
            rdData[BIT_RST_CAUSE] = rstCauseQ;
            rdData[BIT_RST_EN] = rstEnQ;
            rdData[BIT_RESTART] = restartQ;
         end
         OFF_CLK_CTRL: rdData[REG_W-1:0] = clkCtrlQ;
         OFF_TA_KEY: rdData[0] = taOpen;
         OFF_EXT_IE: rdData[REG_W-1:0] = extIeQ;
         OFF_GLB_IE: rdData[BIT_GLB_IE] = glbIeQ;
         OFF_IRQ_STAT: rdData[IRQ_W-1:0] = irqStatQ;
         OFF_IRQ_MASK: rdData[IRQ_W-1:0] = irqMaskQ;
         OFF_COUNT: rdData[CNT_W-1:0] = cntQ;
         default: rdData = '0;
      endcase
   end

endmodule

// *** verilog/wdt_pkg.sv ***
package wdt_pkg;

   // bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned STRB_W = 4;
   localparam int unsigned REG_W = 8;

   // register byte offsets
   localparam logic [7:0] OFF_WD_CTRL = 8'h00;
   localparam logic [7:0] OFF_CLK_CTRL = 8'h04;
   localparam logic [7:0] OFF_TA_KEY = 8'h08;
   localparam logic [7:0] OFF_EXT_IE = 8'h0c;
   localparam logic [7:0] OFF_GLB_IE = 8'h10;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFF_COUNT = 8'h1c;

   // field positions
   localparam int unsigned BIT_RESTART = 0;
   localparam int unsigned BIT_RST_EN = 1;
   localparam int unsigned BIT_RST_CAUSE = 2;
   localparam int unsigned BIT_TIMEOUT = 3;
   localparam int unsigned BIT_SEL_LO = 6;
   localparam int unsigned BIT_SEL_HI = 7;
   localparam int unsigned BIT_WD_IE = 4;
   localparam int unsigned BIT_GLB_IE = 0;
   localparam int unsigned IRQ_W = 2;
   localparam int unsigned IRQ_TIMEOUT = 0;
   localparam int unsigned IRQ_WD_RST = 1;

   // reset values
   localparam logic [7:0] CLK_CTRL_RST = 8'h00;
   localparam logic [7:0] EXT_IE_RST = 8'h00;

   // timing
   localparam int unsigned CNT_W = 26;
   localparam int unsigned DLY_W = 9;
   localparam int unsigned RST_DELAY_CLKS = 512;
   localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(RST_DELAY_CLKS - 1);
   localparam int unsigned CLKS_PER_MC = 4;
   localparam int unsigned RST_PULSE_MC = 2;
   localparam int unsigned PULSE_W = 4;
   localparam logic [PULSE_W-1:0] RST_PULSE_CLKS = PULSE_W'(CLKS_PER_MC * RST_PULSE_MC);
   localparam int unsigned TA_WINDOW_MC = 3;
   localparam int unsigned TA_CNT_W = 4;
   localparam logic [TA_CNT_W-1:0] TA_WINDOW_LAST = TA_CNT_W'(CLKS_PER_MC * TA_WINDOW_MC - 1);
   localparam logic [7:0] TA_KEY_FIRST = 8'haa;
   localparam logic [7:0] TA_KEY_SECOND = 8'h55;

   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {TA_LOCKED, TA_ARMED, TA_OPEN} wdt_ta_state_t;

endpackage

// *** verilog/wdt_axil_slave.sv ***
`timescale 1ns/100ps
module wdt_axil_slave (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [wdt_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [wdt_pkg::STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [wdt_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wrEn,
   output logic [wdt_pkg::ADDR_W-1:0] wrAddr,
   output logic [wdt_pkg::DATA_W-1:0] wrData,
   output logic [wdt_pkg::STRB_W-1:0] wrStrb,
   input wire logic wrErr,
   output logic rdEn,
   input wire logic [wdt_pkg::DATA_W-1:0] rdData,
   input wire logic rdErr
);
   import wdt_pkg::*;

   logic awHeldQ;
   logic wHeldQ;

   // a new address is refused while a response still waits, so one write at a time
   assign s_axi_awready = !awHeldQ && !s_axi_bvalid;
   assign s_axi_wready = !wHeldQ && !s_axi_bvalid;
   assign wrEn = awHeldQ && wHeldQ && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign rdEn = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         awHeldQ <= 1'b0;
         wrAddr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeldQ <= 1'b1;
         wrAddr <= s_axi_awaddr;
      end else if (wrEn) begin
         awHeldQ <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wHeldQ <= 1'b0;
         wrData <= '0;
         wrStrb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeldQ <= 1'b1;
         wrData <= s_axi_wdata;
         wrStrb <= s_axi_wstrb;
      end else if (wrEn) begin
         wHeldQ <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wrEn) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrErr ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (rdEn) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdData;
         s_axi_rresp <= rdErr ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// *** verilog/wdt_timed_access.sv ***
`timescale 1ns/100ps
module wdt_timed_access (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic keyWr,
   input wire logic [wdt_pkg::REG_W-1:0] keyData,
   output logic unlocked
);
   import wdt_pkg::*;

   wdt_ta_state_t stateQ;
   logic [TA_CNT_W-1:0] winQ;

   assign unlocked = (stateQ == TA_OPEN);

   // both keys in order, each step within the window, else back to locked
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stateQ <= TA_LOCKED;
         winQ <= '0;
      end else begin
         case (stateQ)
            TA_LOCKED: begin
               if (keyWr && keyData == TA_KEY_FIRST) begin
                  stateQ <= TA_ARMED;
                  winQ <= TA_WINDOW_LAST;
               end
            end
            TA_ARMED: begin
               if (keyWr) begin
                  stateQ <= (keyData == TA_KEY_SECOND) ? TA_OPEN : TA_LOCKED;
                  winQ <= TA_WINDOW_LAST;
               end else if (winQ == '0) begin
                  stateQ <= TA_LOCKED;
               end else begin
                  winQ <= winQ - 1'b1;
               end
            end
            TA_OPEN: begin
               if (winQ == '0) begin
                  stateQ <= TA_LOCKED;
               end else begin
                  winQ <= winQ - 1'b1;
               end
            end
            default: begin
               stateQ <= TA_LOCKED;
            end
         endcase
      end
   end

endmodule

// *** verif/wdt_unit_checker.sv ***
`timescale 1ns/100ps
module wdt_unit_checker
   import wdt_pkg::*;
#(
   parameter int unsigned TIMEOUT_CLKS_0 = 131072,
   parameter int unsigned TIMEOUT_CLKS_1 = 1048576,
   parameter int unsigned TIMEOUT_CLKS_2 = 8388608,
   parameter int unsigned TIMEOUT_CLKS_3 = 67108864
) (
   input logic clock,
   input logic rst_n,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic [1:0] s_axi_bresp,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic [DATA_W-1:0] s_axi_rdata,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic wdtIrqReq,
   input logic wdtSysRst
);
   // shortest legal gap: one minimum interval plus the fixed delay, less edge slack
   localparam logic [31:0] MIN_GAP = 32'(TIMEOUT_CLKS_0 + RST_DELAY_CLKS - 2);
   logic [31:0] gapCnt_q;
   always_ff @(posedge clock) begin
      if (!rst_n || wdtSysRst) begin
         gapCnt_q <= '0;
      end else if (gapCnt_q != 32'hffffffff) begin
         gapCnt_q <= gapCnt_q + 32'h1;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence pulseBody;
      wdtSysRst [*8] ##1 !wdtSysRst;
   endsequence
   sequence bothTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   chk_pulse_length: assert property ($rose(wdtSysRst) |-> pulseBody)
      else $error("system reset pulse is not eight clocks");
   chk_pulse_spacing: assert property ($rose(wdtSysRst) |-> gapCnt_q >= MIN_GAP)
      else $error("system reset came before time-out plus delay");
   chk_reset_clears_req: assert property ($rose(wdtSysRst) |=> !wdtIrqReq)
      else $error("time-out request survived watchdog reset");
   chk_write_answer: assert property (bothTaken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one cycle after address");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before rready");
   chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data pending");
   chk_write_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
endmodule

bind wdt_unit wdt_unit_checker #(.TIMEOUT_CLKS_0(TIMEOUT_CLKS_0), .TIMEOUT_CLKS_1(TIMEOUT_CLKS_1),
   .TIMEOUT_CLKS_2(TIMEOUT_CLKS_2), .TIMEOUT_CLKS_3(TIMEOUT_CLKS_3)) u_chk (.clock(clock),
   .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .wdtIrqReq(wdtIrqReq), .wdtSysRst(wdtSysRst));

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
   import wdt_pkg::*;
   // shortened intervals keep the run brief; the interval waits below derive from these
   localparam int TC[4] = '{64, 128, 256, 512};
   logic clock = 1'h0;
   logic rst_n = 1'h0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [DATA_W-1:0] wdata = '0;
   logic [STRB_W-1:0] wstrb = '0;
   logic awready, wready, bvalid, arready, rvalid, irq, wdtIrqReq, wdtSysRst, prevRst;
   logic [1:0] bresp, rresp, rs;
   logic [DATA_W-1:0] rdata, rd;
   int err_total = 0, num_checks = 0, pulses = 0, cnt;

   wdt_unit #(.TIMEOUT_CLKS_0(TC[0]), .TIMEOUT_CLKS_1(TC[1]), .TIMEOUT_CLKS_2(TC[2]),
      .TIMEOUT_CLKS_3(TC[3])) DUT (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq(irq), .wdtIrqReq(wdtIrqReq), .wdtSysRst(wdtSysRst));

   initial begin
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      if (wdtSysRst === 1'h1 && prevRst !== 1'h1) pulses++;
      prevRst = wdtSysRst;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      r = 2'h3;
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (r === 2'h3) begin
         @(posedge clock);
         if (awvalid && awready === 1'h1) awvalid <= 1'h0;
         if (wvalid && wready === 1'h1) wvalid <= 1'h0;
         if (bvalid === 1'h1) begin
            r = bresp;
            bready <= 1'h0;
         end
      end
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      r = 2'h3;
      d = '1;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (r === 2'h3) begin
         @(posedge clock);
         if (arvalid && arready === 1'h1) arvalid <= 1'h0;
         if (rvalid === 1'h1) begin
            r = rresp;
            d = rdata;
            rready <= 1'h0;
         end
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      check("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
   endtask
   task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] m, e);
      logic [1:0] r;
      logic [31:0] d;
      axi_rd(a, d, r);
      check(n, d & m, e);
   endtask
   // guarded control write: key pair lands well inside the unlock window
   task automatic wctl(input logic [31:0] d);
      wr(OFF_TA_KEY, {24'h0, TA_KEY_FIRST});
      wr(OFF_TA_KEY, {24'h0, TA_KEY_SECOND});
      wr(OFF_WD_CTRL, d);
   endtask

   initial begin
      #(20000 * 50);
      err_total++;
      complete_run();
   end

   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'h1;
      rdchk("ctrl reset", OFF_WD_CTRL, 32'hff, 32'h0);
      rdchk("interval reset", OFF_CLK_CTRL, 32'hc0, {24'h0, CLK_CTRL_RST});
      axi_wr(8'h20, 32'h1, rs);
      check("unmapped bresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
      axi_rd(8'h20, rd, rs);
      check("unmapped rresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
      check("unmapped rdata", rd, 32'h0);
      wr(OFF_WD_CTRL, 32'h3);
      rdchk("unguarded write", OFF_WD_CTRL, 32'h3, 32'h0);
      for (int s = 0; s < 4; s++) begin
         wr(OFF_CLK_CTRL, 32'(s) << BIT_SEL_LO);
         wctl(32'h1);
         rdchk("counter restart", OFF_COUNT, 32'hffffffe0, 32'h0);
         rdchk("restart self clear", OFF_WD_CTRL, 32'h1, 32'h0);
         repeat (TC[s] - 40) @(posedge clock);
         rdchk("flag early", OFF_WD_CTRL, 32'h8, 32'h0);
         repeat (40) @(posedge clock);
         rdchk("flag set", OFF_WD_CTRL, 32'h8, 32'h8);
      end
      wctl(32'h0);
      rdchk("flag cleared", OFF_WD_CTRL, 32'h8, 32'h0);
      repeat (TC[3] + 8) @(posedge clock);
      rdchk("flag again", OFF_WD_CTRL, 32'h8, 32'h8);
      wr(OFF_IRQ_MASK, 32'h1);
      check("irq unmasked", {31'h0, irq}, 32'h1);
      wr(OFF_IRQ_STAT, 32'h1);
      check("irq cleared", {31'h0, irq}, 32'h0);
      wr(OFF_IRQ_MASK, 32'h2);
      check("irq masked", {31'h0, irq}, 32'h0);
      wr(OFF_EXT_IE, 32'h10);
      check("req no global", {31'h0, wdtIrqReq}, 32'h0);
      wr(OFF_GLB_IE, 32'h1);
      check("req both", {31'h0, wdtIrqReq}, 32'h1);
      check("no reset", 32'(pulses), 32'h0);
      wr(OFF_CLK_CTRL, 32'h0);
      wctl(32'h3);
      cnt = 0;
      while (wdtSysRst !== 1'h1 && cnt < 800) begin
         @(posedge clock);
         cnt++;
      end
      check("reset delay", 32'(cnt >= 570 && cnt <= 582), 32'h1);
      repeat (12) @(posedge clock);
      rdchk("reset cause", OFF_WD_CTRL, 32'he, 32'h6);
      check("reset event irq", {31'h0, irq}, 32'h1);
      for (int k = 0; k < 4; k++) begin
         wctl(32'h3);
         repeat (400) @(posedge clock);
      end
      check("kept alive", 32'(pulses), 32'h1);
      wr(OFF_WD_CTRL, 32'h0);
      rdchk("cause cleared", OFF_WD_CTRL, 32'h6, 32'h2);
      wctl(32'h1);
      repeat (TC[0] + RST_DELAY_CLKS + 100) @(posedge clock);
      check("reset disabled", 32'(pulses), 32'h1);
      rdchk("cause untouched", OFF_WD_CTRL, 32'hc, 32'h8);
      rst_n <= 1'h0;
      repeat (6) @(posedge clock);
      rst_n <= 1'h1;
      rdchk("power reset", OFF_WD_CTRL, 32'hff, 32'h0);
      check("irq after reset", {31'h0, irq}, 32'h0);
      complete_run();
   end
endmodule
